// file: inc/rrf_defines.svh
/*
 * constants for the run-control and hour-format block: register addresses,
 * field positions and reset values.
 * assumes it is included by bare name from a design file or package.
 */
`ifndef RRF_DEFINES_SVH
`define RRF_DEFINES_SVH

`define RRF_ADDR_CTRL_D        4'hD
`define RRF_ADDR_CTRL_E        4'hE
`define RRF_ADDR_CTRL_F        4'hF

`define RRF_BIT_SUBSEC_RST     0
`define RRF_BIT_STOP           1
`define RRF_BIT_FMT24          2
`define RRF_BIT_TEST           3
`define RRF_BIT_IRQ_FLAG       2
`define RRF_BIT_STYLE          1
`define RRF_BIT_PSEL_LOW       2
`define RRF_BIT_PSEL_HIGH      3

`define RRF_CTRL_F_RESET       4'h0
`define RRF_FMT_SEQ_IDLE_V     1'b0

`endif

// file: inc/rrf_pkg.sv
/*
 * types shared by the run-control block.
 * assumes rrf_defines.svh sits on the include path.
 */
`include "rrf_defines.svh"

package rrf_pkg;
    // hour-format write sequence: waiting for the reset-set write, then its partner
    typedef enum logic [0:0]
    {
        RRF_FMT_IDLE  = 1'b0,
        RRF_FMT_ARMED = 1'b1
    } rrf_fmt_state_t;
endpackage : rrf_pkg

// file: verilog/rrf_run_control.sv
/*
 * run-control, hour-format and irq-flag write handling of a 4-bit bus rtc.
 * assumes host strobes and chip select come from pins (synchronised here) and
 * that the periodic output generator reports period events only; the pin is driven here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rrf_defines.svh"

module rrf_run_control
    import rrf_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       primary_chip_select,
    input  wire logic       write_strobe,
    input  wire logic [3:0] address,
    input  wire logic [3:0] write_data,
    input  wire logic       irq_event,
    input  wire logic       sec_carry_in,
    output logic      [3:0] read_data,
    output logic            irq_flag,
    output logic            periodic_output_pin_oe,
    output logic            periodic_output_pin,
    output logic            subsecond_reset,
    output logic            counting_stopped,
    output logic            hour_mode_24,
    output logic            meridiem_enable,
    output logic            test_mode,
    output logic            sec_carry_out
);

    // pin synchronisers; first stage is read only by the second
    logic [1:0] cs_sync_ff;
    logic [1:0] wr_sync_ff;
    logic       wr_prev_ff;
    logic [3:0] addr_meta_ff;
    logic [3:0] addr_ff;
    logic [3:0] data_meta_ff;
    logic [3:0] data_ff;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cs_sync_ff <= 2'h0;
            wr_sync_ff <= 2'h0;
            wr_prev_ff <= 1'b0;
            addr_meta_ff <= 4'h0;
            addr_ff      <= 4'h0;
            data_meta_ff <= 4'h0;
            data_ff      <= 4'h0;
        end
        else
        begin
            cs_sync_ff <= {cs_sync_ff[0], primary_chip_select};
            wr_sync_ff <= {wr_sync_ff[0], write_strobe};
            wr_prev_ff <= wr_sync_ff[1];
            // bus pins ride the same two stages as the strobe, so they line up with it
            addr_meta_ff <= address;
            addr_ff      <= addr_meta_ff;
            data_meta_ff <= write_data;
            data_ff      <= data_meta_ff;
        end
    end

    // address match, shared by the write decode and the read mux
    function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] target);
        return (a == target);
    endfunction : addr_hit

    // decode of a write, taken on the rising synced strobe
    wire cs_ok    = cs_sync_ff[1];
    wire wr_pulse = cs_ok & wr_sync_ff[1] & ~wr_prev_ff;
    wire hit_f    = addr_hit(addr_ff, `RRF_ADDR_CTRL_F);
    wire hit_d    = addr_hit(addr_ff, `RRF_ADDR_CTRL_D);
    wire wr_f     = wr_pulse & hit_f;
    wire wr_d     = wr_pulse & hit_d;

    // run-control register
    logic           rst_bit_ff, stop_bit_ff, fmt_bit_ff, test_bit_ff;
    logic           nxt_rst_bit, nxt_stop_bit, nxt_fmt_bit, nxt_test_bit;
    rrf_fmt_state_t fmt_seq_ff, nxt_fmt_seq;

    // reset image of the run-control register, sliced per bit below
    localparam logic [3:0] CTRL_F_RESET_V = `RRF_CTRL_F_RESET;

    // chip select low wins over any write to the reset bit
    assign nxt_rst_bit  = !cs_ok ? 1'b0 :
                          wr_f ? data_ff[`RRF_BIT_SUBSEC_RST] : rst_bit_ff;
    assign nxt_stop_bit = wr_f ? data_ff[`RRF_BIT_STOP] : stop_bit_ff;
    assign nxt_test_bit = wr_f ? data_ff[`RRF_BIT_TEST] : test_bit_ff;
    // format lands only when reset is already 1 at the write
    assign nxt_fmt_bit  = (wr_f && rst_bit_ff) ? data_ff[`RRF_BIT_FMT24]
                                               : fmt_bit_ff;

    // track the two-write sequence; informational, value is taken per write
    always_comb
    begin
        nxt_fmt_seq = fmt_seq_ff;
        case (fmt_seq_ff)
            RRF_FMT_IDLE:
                if (wr_f && data_ff[`RRF_BIT_SUBSEC_RST])
                    nxt_fmt_seq = RRF_FMT_ARMED;
            RRF_FMT_ARMED:
                if (wr_f || !cs_ok)
                    nxt_fmt_seq = RRF_FMT_IDLE;
            default:
                nxt_fmt_seq = RRF_FMT_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rst_bit_ff  <= CTRL_F_RESET_V[`RRF_BIT_SUBSEC_RST];
            stop_bit_ff <= CTRL_F_RESET_V[`RRF_BIT_STOP];
            fmt_bit_ff  <= CTRL_F_RESET_V[`RRF_BIT_FMT24];
            test_bit_ff <= CTRL_F_RESET_V[`RRF_BIT_TEST];
            fmt_seq_ff  <= RRF_FMT_IDLE;
        end
        else
        begin
            rst_bit_ff  <= nxt_rst_bit;
            stop_bit_ff <= nxt_stop_bit;
            fmt_bit_ff  <= nxt_fmt_bit;
            test_bit_ff <= nxt_test_bit;
            fmt_seq_ff  <= nxt_fmt_seq;
        end
    end

    // irq flag: event set beats a write clear landing on the same edge
    logic irq_ff;
    logic nxt_irq;
    wire  irq_clear = wr_d & ~data_ff[`RRF_BIT_IRQ_FLAG];
    assign nxt_irq  = irq_event ? 1'b1 : (irq_clear ? 1'b0 : irq_ff);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            irq_ff <= 1'b0;
        else
            irq_ff <= nxt_irq;
    end

    // open-drain pin: driven low exactly while the flag is 1
    assign periodic_output_pin    = 1'b0;
    assign periodic_output_pin_oe = irq_ff;
    assign irq_flag               = irq_ff;

    // run outputs and carry gating into the calendar chain
    assign subsecond_reset  = rst_bit_ff;
    assign counting_stopped = stop_bit_ff;
    assign hour_mode_24     = fmt_bit_ff;
    assign meridiem_enable  = ~fmt_bit_ff;
    assign test_mode        = test_bit_ff;
    assign sec_carry_out    = sec_carry_in & ~stop_bit_ff & ~rst_bit_ff;

    // read mux, registered so data outputs come from flip-flops
    logic [3:0] nxt_read;
    assign nxt_read = hit_f ? {test_bit_ff, fmt_bit_ff, stop_bit_ff, rst_bit_ff} :
                      hit_d ? {1'b0, irq_ff, 2'h0} : 4'h0;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            read_data <= 4'h0;
        else
            read_data <= nxt_read;
    end

    // checks beside the logic
    a_cs_low_resets: assert property (@(posedge clock) disable iff (!rst_n)
        !cs_sync_ff[1] |=> !subsecond_reset) else $error("reset bit kept with cs low");
    a_fmt_locked: assert property (@(posedge clock) disable iff (!rst_n)
        !rst_bit_ff |=> $stable(fmt_bit_ff)) else $error("format changed out of reset");
    a_fmt_taken: assert property (@(posedge clock) disable iff (!rst_n)
        wr_f && rst_bit_ff |=> fmt_bit_ff == $past(data_ff[`RRF_BIT_FMT24]))
        else $error("format not taken");
    a_rst_holds: assert property (@(posedge clock) disable iff (!rst_n)
        rst_bit_ff && cs_ok && !wr_f |=> rst_bit_ff) else $error("reset bit dropped");
    a_stop_write: assert property (@(posedge clock) disable iff (!rst_n)
        wr_f |=> stop_bit_ff == $past(data_ff[`RRF_BIT_STOP])) else $error("stop not written");
    a_meridiem_mode: assert property (@(posedge clock) disable iff (!rst_n)
        meridiem_enable != hour_mode_24) else $error("meridiem mismatch");
    a_fmt_readback: assert property (@(posedge clock) disable iff (!rst_n)
        hit_f |=> read_data[`RRF_BIT_FMT24] == $past(fmt_bit_ff))
        else $error("format readback wrong");
    a_irq_clear: assert property (@(posedge clock) disable iff (!rst_n)
        irq_clear && !irq_event |=> !irq_flag) else $error("flag not cleared");
    a_irq_no_set: assert property (@(posedge clock) disable iff (!rst_n)
        !irq_flag && !irq_event |=> !irq_flag) else $error("flag set by write");
    // a request landing on the same edge as a clear must not be lost
    a_irq_set_wins: assert property (@(posedge clock) disable iff (!rst_n)
        irq_event |=> irq_flag) else $error("flag not set by event");
    a_pin_follows: assert property (@(posedge clock) disable iff (!rst_n)
        periodic_output_pin_oe == irq_flag) else $error("pin and flag differ");
    a_carry_gated: assert property (@(posedge clock) disable iff (!rst_n)
        (stop_bit_ff || rst_bit_ff) |-> !sec_carry_out) else $error("carry while frozen");
    a_carry_passes: assert property (@(posedge clock) disable iff (!rst_n)
        !stop_bit_ff && !rst_bit_ff |-> sec_carry_out == sec_carry_in)
        else $error("carry lost while running");

    c_fmt_seq:  cover property (@(posedge clock) disable iff (!rst_n)
        fmt_seq_ff == RRF_FMT_ARMED ##[1:20] wr_f && !data_ff[`RRF_BIT_SUBSEC_RST]);
    c_irq_race: cover property (@(posedge clock) disable iff (!rst_n) irq_event && irq_clear);
    c_stopped:  cover property (@(posedge clock) disable iff (!rst_n) stop_bit_ff && sec_carry_in);
    c_cs_drop:  cover property (@(posedge clock) disable iff (!rst_n) rst_bit_ff && !cs_ok);

endmodule : rrf_run_control
`default_nettype wire

// file: verification/rrf_host_model.sv
/*
 * host bus model: drives chip select, write strobe, address and data.
 * assumes the block samples these on its own clock through synchronisers.
 */
`timescale 1ns/1ps
`default_nettype none

module rrf_host_model
(
    input  wire logic       clock,
    output logic            cs,
    output logic            strobe,
    output logic      [3:0] addr,
    output logic      [3:0] data
);
    // bus idle, chip deselected until the bench selects it
    initial
    begin
        cs     = 1'b0;
        strobe = 1'b0;
        addr   = 4'h0;
        data   = 4'hF;
    end

    // callers keep the test bit 0 and flag 1 unless clearing
    // callers clear the flag after period rewrites and redo hours
    // strobe held past the two-flop sync so the write is seen once
    task automatic write_reg(input logic [3:0] a, input logic [3:0] d);
        begin
            @(posedge clock);
            addr   <= a;
            data   <= d;
            strobe <= 1'b1;
            repeat (5) @(posedge clock);
            strobe <= 1'b0;
            repeat (4) @(posedge clock);
            data   <= ~d; // released bus, old value not kept
        end
    endtask : write_reg

    // change chip select and let the synchroniser catch up
    task automatic select(input logic v);
        begin
            @(posedge clock);
            cs <= v;
            repeat (3) @(posedge clock);
        end
    endtask : select
endmodule : rrf_host_model

`default_nettype wire

// file: verification/tb_rrf_run_control.sv
/*
 * self-checking bench for the run-control block.
 * assumes the host model owns the bus pins.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_rrf_run_control;
    logic       clock        = 1'b0;
    logic       rst_n        = 1'b0;
    logic       irq_event    = 1'b0;
    logic       sec_carry_in = 1'b0;
    logic       cs, strobe, irq_flag, pin_oe, subsec, stopped, mode24, mer_en, sco;
    logic       test_on, pin_lvl;
    logic [3:0] addr, data, read_data;
    int         n_fail       = 0;
    int         n_tests      = 0;

    always #12.5 clock = ~clock;

    rrf_host_model rrf_host_model_inst (.clock(clock), .cs(cs), .strobe(strobe),
        .addr(addr), .data(data));
    rrf_run_control rrf_run_control_inst (.clock(clock), .rst_n(rst_n),
        .primary_chip_select(cs), .write_strobe(strobe), .address(addr),
        .write_data(data), .irq_event(irq_event), .sec_carry_in(sec_carry_in),
        .read_data(read_data), .irq_flag(irq_flag), .periodic_output_pin_oe(pin_oe),
        .periodic_output_pin(pin_lvl), .subsecond_reset(subsec), .counting_stopped(stopped),
        .hour_mode_24(mode24), .meridiem_enable(mer_en), .test_mode(test_on),
        .sec_carry_out(sco));

    // compare a settled 4-bit result
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        begin
            n_tests++;
            if (got !== exp)
            begin
                n_fail++;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask : chk

    // one write, then wait for the falling edge so outputs have landed
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        begin
            rrf_host_model_inst.write_reg(a, d);
            @(negedge clock);
        end
    endtask : wr

    // one carry pulse, judged while it stands
    task automatic carry(input logic exp);
        begin
            @(posedge clock);
            sec_carry_in <= 1'b1;
            @(negedge clock);
            chk({3'h0, sco}, {3'h0, exp});
            @(posedge clock);
            sec_carry_in <= 1'b0;
        end
    endtask : carry

    // one-cycle request from the periodic generator
    task automatic fire;
        begin
            @(posedge clock);
            irq_event <= 1'b1;
            @(posedge clock);
            irq_event <= 1'b0;
            repeat (3) @(negedge clock);
        end
    endtask : fire

    // format only moves when reset was already set
    task automatic t_format;
        begin
            wr(4'hF, 4'h5);
            chk({3'h0, mode24}, 4'h0);
            chk({3'h0, test_on}, 4'h0);
            chk(read_data, 4'h1);
            wr(4'hF, 4'h4);
            chk({3'h0, mode24}, 4'h1);
            chk({3'h0, mer_en}, 4'h0);
            wr(4'hF, 4'h0);
            chk(read_data, 4'h4);
            wr(4'hF, 4'h1);
            wr(4'hF, 4'h0);
            chk({3'h0, mer_en}, 4'h1);
        end
    endtask : t_format

    // stop and sub-second reset gate the carry; deselect drops reset
    task automatic t_run;
        begin
            wr(4'hF, 4'h2);
            chk({3'h0, stopped}, 4'h1);
            chk(read_data, 4'h2);
            carry(1'b0);
            wr(4'hF, 4'h1);
            carry(1'b0);
            rrf_host_model_inst.select(1'b0);
            @(negedge clock);
            chk({3'h0, subsec}, 4'h0);
            rrf_host_model_inst.select(1'b1);
            wr(4'hF, 4'h0);
            carry(1'b1);
            chk({3'h0, stopped}, 4'h0);
        end
    endtask : t_run

    // flag set by events, cleared only by a written 0
    task automatic t_irq;
        begin
            wr(4'hD, 4'h4);
            chk(read_data, 4'h0);
            fire();
            chk(read_data, 4'h4);
            chk({3'h0, pin_oe}, 4'h1);
            chk({3'h0, pin_lvl}, 4'h0);
            wr(4'hD, 4'h4);
            chk({3'h0, irq_flag}, 4'h1);
            wr(4'hD, 4'h0);
            chk({3'h0, pin_oe}, 4'h0);
            fire();
            wr(4'hD, 4'h1);
            chk(read_data, 4'h0);
            wr(4'hE, 4'hC);
            chk(read_data, 4'h0);
            wr(4'hD, 4'h0);
            chk({3'h0, irq_flag}, 4'h0);
            // request lands on the very edge that takes the clear; the request wins
            fork
                wr(4'hD, 4'h0);
                begin
                    repeat (3) @(posedge clock);
                    irq_event <= 1'b1;
                    @(posedge clock);
                    irq_event <= 1'b0;
                end
            join
            chk({3'h0, irq_flag}, 4'h1);
            wr(4'hD, 4'h0);
            chk({3'h0, irq_flag}, 4'h0);
        end
    endtask : t_irq

    // mid-run reset clears the reset, stop and format bits and the flag
    task automatic t_reset;
        begin
            wr(4'hF, 4'h1);
            wr(4'hF, 4'h7);
            chk({1'b0, subsec, stopped, mode24}, 4'h7);
            fire();
            @(posedge clock);
            rst_n <= 1'b0;
            repeat (2) @(posedge clock);
            rst_n <= 1'b1;
            @(negedge clock);
            chk({subsec, stopped, mode24, irq_flag}, 4'h0);
            chk(read_data, 4'h0);
        end
    endtask : t_reset

    task automatic give_verdict;
        begin
            $display("checks=%0d mismatches=%0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask : give_verdict

    // main sequence after an 8-cycle reset
    initial
    begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rrf_host_model_inst.select(1'b1);
        t_format();
        t_run();
        t_irq();
        t_reset();
        give_verdict();
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #100000;
        n_fail++;
        give_verdict();
    end
endmodule : tb_rrf_run_control

`default_nettype wire
